// file: drs_map.svh
// Constants of the run and stop sequencer
`ifndef DRS_MAP_SVH
`define DRS_MAP_SVH

// Clock and internal time base
`define DRS_CLK_PERIOD_NS   8
`define DRS_TICK_PERIOD_NS  10000000
`define DRS_TICK_CNT_W      21
`define DRS_TICK_MS         10

// Three-wire start must be held this long
`define DRS_START_HOLD_MS   50

// Output frequency steps used for stop-time scaling
`define DRS_FREQ_STEPS      10

// Multi-function input selector codes and reset values
`define DRS_MFI_NUM         6
`define DRS_MFI_W           8
`define DRS_MFI_THREE_WIRE  8'h00
`define DRS_MFI_DC_BRAKE    8'h3c
`define DRS_MFI_UNUSED      8'hff
`define DRS_MFI_DIR_POS     0

// Run source and stop method codes
`define DRS_SRC_PANEL       1'h0
`define DRS_SRC_TERMINAL    1'h1
`define DRS_STOP_RAMP       2'h0
`define DRS_STOP_COAST      2'h1
`define DRS_STOP_DC         2'h2
`define DRS_STOP_TIMED      2'h3

// Timer width
`define DRS_TMR_W           20

`endif

// file: drs_pkg.sv
// Types of the run and stop sequencer
package drs_pkg;

    typedef enum logic [2:0] {
        DRS_IDLE     = 3'h0,
        DRS_START_DC = 3'h1,
        DRS_RUN      = 3'h3,
        DRS_DECEL    = 3'h2,
        DRS_STOP_DC  = 3'h6,
        DRS_BBLOCK   = 3'h7,
        DRS_LOCKOUT  = 3'h5,
        DRS_ZSERVO   = 3'h4
    } drs_state_t;

    typedef struct packed {
        drs_state_t        st;
        logic [20:0]       tick_cnt;
        logic [5:0][7:0]   mfi;
        logic              pnl_run;
        logic              pnl_rev;
        logic              wire3_run;
        logic              dir_rev;
        logic              dc_after;
        logic [7:0]        dc_cur;
    } drs_seq_t;

endpackage

// file: drs_tmr_if.sv
// Load and expiry signals between sequencer and a countdown timer
`timescale 1ns/10ps
interface drs_tmr_if #(
    parameter int W = 20
);
    logic         load;
    logic [W-1:0] value;
    logic         tick;
    logic         expired;

    modport ctrl (output load, output value, output tick, input expired);
    modport tmr  (input load, input value, input tick, output expired);
endinterface

// file: drs_timer.sv
// Countdown timer clocked by the time-base tick
`timescale 1ns/10ps
module drs_timer #(
    parameter int W = 20
) (
    // Clock and reset
    input  wire logic i_clk,
    input  wire logic i_srst,
    // Timer control
    drs_tmr_if.tmr    tif
);
    typedef struct packed {
        logic [W-1:0] cnt;
    } drs_tmr_state_t;

    drs_tmr_state_t cur_ff;
    drs_tmr_state_t nxt_cur;

    always_comb begin
        nxt_cur = cur_ff;
        if (tif.load) begin
            nxt_cur.cnt = tif.value;
        end else if (tif.tick && (cur_ff.cnt != '0)) begin
            nxt_cur.cnt = cur_ff.cnt - W'(1);
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            cur_ff <= '0;
        end else begin
            cur_ff <= nxt_cur;
        end
    end

    // Zero load expires on the next cycle: skipped phases cost one clock
    assign tif.expired = (cur_ff.cnt == '0);
endmodule

// file: drs_sequencer.sv
// Run source, terminal decode and stop method sequencer of a motor drive
// Contract
// (RL1) Source 0: run from operator panel keys
// (RL2) Source 1: run from control terminals
// (RL3) Two-wire: forward input runs, release stops
// (RL4) Two-wire: reverse input runs, release stops
// (RL5) Factory initialization gives two-wire control
// (RL6) Selector code 0 anywhere enables three-wire
// (RL7) Three-wire initialization presets third terminal direction
// (RL8) Start held 50 ms latches run command
// (RL9) Stop method codes 0 to 3
// (RL10) Closed-loop vector rejects codes 2 and 3
// (RL11) Method 0 ramps down on stop
// (RL12) Below zero speed, DC brake stop time
// (RL13) Closed-loop vector ramp end uses zero-speed selector
// (RL14) Method 1 cuts output, motor coasts
// (RL15) Run ignored until minimum baseblock elapses
// (RL16) Method 2: baseblock then scaled DC brake
// (RL17) Method 3: coast, lockout scaled by frequency
// (RL18) Zero brake time skips automatic DC injection
// (RL19) Brake current unavailable under closed-loop vector
// (RL20) Selector code 60 is external DC brake
// (RL21) External brake below zero speed injects DC
// (RL22) Durations counted on fixed tick, reloaded
`timescale 1ns/10ps
`include "drs_map.svh"
module drs_sequencer #(
    parameter int unsigned TICK_CYCLES =
        `DRS_TICK_PERIOD_NS / `DRS_CLK_PERIOD_NS
) (
    // Clock and reset
    input  wire logic        i_clk,
    input  wire logic        i_srst,
    // Configuration
    input  wire logic        i_run_source_select,
    input  wire logic [1:0]  i_stop_method_select,
    input  wire logic        i_closed_loop_vector,
    input  wire logic [1:0]  i_zero_speed_op_select,
    input  wire logic [15:0] i_zero_speed_level,
    input  wire logic [7:0]  i_dc_brake_current,
    input  wire logic [15:0] i_dc_brake_time_start,
    input  wire logic [15:0] i_dc_brake_time_stop,
    input  wire logic [15:0] i_min_baseblock_time,
    input  wire logic [15:0] i_decel_time_one,
    input  wire logic [15:0] i_max_freq,
    // Multi-function input selectors
    input  wire logic        i_init_pulse,
    input  wire logic        i_init_three_wire,
    input  wire logic        i_mfi_wr,
    input  wire logic [2:0]  i_mfi_idx,
    input  wire logic [7:0]  i_mfi_val,
    // Panel keys, one-cycle pulses
    input  wire logic        i_key_run,
    input  wire logic        i_key_stop,
    input  wire logic        i_key_dir,
    // Terminals
    input  wire logic        i_forward_run_input,
    input  wire logic        i_reverse_run_input,
    input  wire logic [5:0]  i_multi_inputs,
    // Frequencies from the ramp generator
    input  wire logic [15:0] i_output_freq,
    input  wire logic [15:0] i_freq_ref,
    // Drive commands
    output logic             o_run_fwd,
    output logic             o_run_rev,
    output logic             o_decel,
    output logic             o_base_block,
    output logic             o_dc_inject,
    output logic             o_zero_servo,
    output logic [7:0]       o_dc_current,
    // Status
    output logic             o_run_locked,
    output logic             o_three_wire,
    output logic             o_method_reject,
    output logic [2:0]       o_state
);
    localparam int TW = `DRS_TMR_W;
    localparam logic [TW-1:0] HOLD_TICKS =
        TW'(`DRS_START_HOLD_MS / `DRS_TICK_MS);

    drs_pkg::drs_seq_t cur_ff;
    drs_pkg::drs_seq_t nxt_cur;

    drs_tmr_if #(.W(TW)) seq_tif ();
    drs_tmr_if #(.W(TW)) hold_tif ();

    drs_timer #(.W(TW)) u_seq_timer (
        .i_clk  (i_clk),
        .i_srst (i_srst),
        .tif    (seq_tif.tmr)
    );

    drs_timer #(.W(TW)) u_hold_timer (
        .i_clk  (i_clk),
        .i_srst (i_srst),
        .tif    (hold_tif.tmr)
    );

    logic            tick;
    logic            three_wire;
    logic            dir_in;
    logic            ext_dc;
    logic            run_cmd;
    logic            run_rev_req;
    logic [1:0]      method;
    logic            method_reject_w;
    logic            below_zs;
    logic            ref_below_zs;
    logic [3:0]      freq_k;
    logic [3:0]      freq_k1;
    logic [19:0]     f_x10;
    logic [TW-1:0]   stop_dc_ticks;
    logic [TW-1:0]   lock_ticks;

    assign tick = (cur_ff.tick_cnt == 21'(TICK_CYCLES - 1)); // RL22

    // Decode of the selector table
    always_comb begin
        three_wire = 1'b0;
        dir_in     = 1'b0;
        ext_dc     = 1'b0;
        for (int i = 0; i < `DRS_MFI_NUM; i++) begin
            if (cur_ff.mfi[i] == `DRS_MFI_THREE_WIRE) begin
                three_wire = 1'b1; // RL6
                dir_in     = dir_in | i_multi_inputs[i];
            end
            if (cur_ff.mfi[i] == `DRS_MFI_DC_BRAKE) begin
                ext_dc = ext_dc | i_multi_inputs[i]; // RL20
            end
        end
    end

    // Effective run request and direction
    always_comb begin
        run_cmd     = 1'b0;
        run_rev_req = 1'b0;
        if (i_run_source_select == `DRS_SRC_PANEL) begin
            run_cmd     = cur_ff.pnl_run; // RL1
            run_rev_req = cur_ff.pnl_rev;
        end else if (three_wire) begin
            run_cmd     = cur_ff.wire3_run; // RL2
            run_rev_req = dir_in; // RL6
        end else begin
            // Both closed counts as no run, never a guess at direction
            run_cmd     = i_forward_run_input ^ i_reverse_run_input;
            run_rev_req = i_reverse_run_input; // RL3 RL4
        end
    end

    // Codes 2 and 3 fall back to ramp-down under closed-loop vector
    assign method_reject_w = i_closed_loop_vector
        && (i_stop_method_select[1] == 1'b1); // RL10
    assign method = method_reject_w ? `DRS_STOP_RAMP
                                    : i_stop_method_select; // RL9

    assign below_zs     = (i_output_freq < i_zero_speed_level);
    assign ref_below_zs = (i_freq_ref < i_zero_speed_level);

    // Output frequency as tenths of maximum, no divider needed
    always_comb begin
        f_x10  = 20'(i_output_freq) * 20'd10;
        freq_k = 4'h0;
        for (int j = 1; j <= `DRS_FREQ_STEPS; j++) begin
            if (f_x10 >= 20'(i_max_freq) * 20'(j)) begin
                freq_k = 4'(j);
            end
        end
    end

    assign freq_k1       = (freq_k == 4'h0) ? 4'h1 : freq_k;
    assign stop_dc_ticks = TW'(i_dc_brake_time_stop * freq_k1); // RL16
    assign lock_ticks    = TW'(i_decel_time_one * freq_k); // RL17

    // Three-wire start hold: reload while released
    assign hold_tif.tick  = tick;
    assign hold_tif.load  = !i_forward_run_input;
    assign hold_tif.value = HOLD_TICKS;

    always_comb begin
        nxt_cur       = cur_ff;
        seq_tif.load  = 1'b0;
        seq_tif.value = '0;
        seq_tif.tick  = tick;

        nxt_cur.tick_cnt = tick ? 21'h0 : cur_ff.tick_cnt + 21'h1;

        if (i_init_pulse) begin
            nxt_cur.mfi = {`DRS_MFI_NUM{`DRS_MFI_UNUSED}};
            if (i_init_three_wire) begin
                nxt_cur.mfi[`DRS_MFI_DIR_POS] = `DRS_MFI_THREE_WIRE; // RL7
            end
        end else if (i_mfi_wr && (i_mfi_idx < 3'(`DRS_MFI_NUM))) begin
            nxt_cur.mfi[i_mfi_idx] = i_mfi_val;
        end

        // Panel keys only count while the panel owns the run command
        if (i_run_source_select != `DRS_SRC_PANEL || i_key_stop) begin
            nxt_cur.pnl_run = 1'b0; // RL1
        end else if (i_key_run) begin
            nxt_cur.pnl_run = 1'b1;
        end
        if (i_run_source_select == `DRS_SRC_PANEL && i_key_dir) begin
            nxt_cur.pnl_rev = !cur_ff.pnl_rev;
        end

        // Stop contact is normally closed; stop wins over start
        if (!three_wire || !i_reverse_run_input) begin
            nxt_cur.wire3_run = 1'b0;
        end else if (i_forward_run_input && hold_tif.expired) begin
            nxt_cur.wire3_run = 1'b1; // RL8
        end

        // Brake current is a held data output
        nxt_cur.dc_cur = i_closed_loop_vector ? 8'h00
                                              : i_dc_brake_current; // RL19

        case (cur_ff.st)
            drs_pkg::DRS_IDLE: begin
                if (run_cmd) begin
                    nxt_cur.dir_rev = run_rev_req;
                    if (i_dc_brake_time_start != 16'h0000) begin
                        seq_tif.load  = 1'b1;
                        seq_tif.value = TW'(i_dc_brake_time_start);
                        nxt_cur.st    = drs_pkg::DRS_START_DC;
                    end else begin
                        nxt_cur.st = drs_pkg::DRS_RUN; // RL18
                    end
                end
            end
            drs_pkg::DRS_START_DC: begin
                if (!run_cmd) begin
                    nxt_cur.st = drs_pkg::DRS_IDLE;
                end else if (seq_tif.expired) begin
                    nxt_cur.st = drs_pkg::DRS_RUN;
                end
            end
            drs_pkg::DRS_RUN: begin
                if (!run_cmd) begin
                    nxt_cur.dc_after = 1'b0;
                    case (method)
                        `DRS_STOP_RAMP: begin
                            nxt_cur.st = drs_pkg::DRS_DECEL; // RL11
                        end
                        `DRS_STOP_COAST: begin
                            seq_tif.load  = 1'b1; // RL14
                            seq_tif.value = TW'(i_min_baseblock_time);
                            nxt_cur.st    = drs_pkg::DRS_BBLOCK; // RL15
                        end
                        `DRS_STOP_DC: begin
                            seq_tif.load     = 1'b1;
                            seq_tif.value    = TW'(i_min_baseblock_time);
                            nxt_cur.dc_after = 1'b1; // RL16
                            nxt_cur.st       = drs_pkg::DRS_BBLOCK;
                        end
                        default: begin
                            seq_tif.load  = 1'b1;
                            seq_tif.value = lock_ticks; // RL17
                            nxt_cur.st    = drs_pkg::DRS_LOCKOUT;
                        end
                    endcase
                end
            end
            drs_pkg::DRS_DECEL: begin
                if (run_cmd) begin
                    nxt_cur.st = drs_pkg::DRS_RUN;
                end else if (below_zs) begin
                    if (i_closed_loop_vector) begin
                        if (i_zero_speed_op_select != 2'h0) begin
                            seq_tif.load  = 1'b1; // RL13
                            seq_tif.value = TW'(i_dc_brake_time_stop);
                            nxt_cur.st    = drs_pkg::DRS_ZSERVO;
                        end else begin
                            nxt_cur.st = drs_pkg::DRS_IDLE;
                        end
                    end else if (i_dc_brake_time_stop != 16'h0000) begin
                        seq_tif.load  = 1'b1; // RL12
                        seq_tif.value = TW'(i_dc_brake_time_stop);
                        nxt_cur.st    = drs_pkg::DRS_STOP_DC;
                    end else begin
                        nxt_cur.st = drs_pkg::DRS_IDLE; // RL18
                    end
                end
            end
            drs_pkg::DRS_BBLOCK: begin
                if (seq_tif.expired) begin
                    if (cur_ff.dc_after
                        && (i_dc_brake_time_stop != 16'h0000)) begin
                        seq_tif.load  = 1'b1;
                        seq_tif.value = stop_dc_ticks; // RL16
                        nxt_cur.st    = drs_pkg::DRS_STOP_DC;
                    end else begin
                        nxt_cur.st = drs_pkg::DRS_IDLE; // RL15
                    end
                end
            end
            drs_pkg::DRS_STOP_DC,
            drs_pkg::DRS_ZSERVO,
            drs_pkg::DRS_LOCKOUT: begin
                if (seq_tif.expired) begin
                    nxt_cur.st = drs_pkg::DRS_IDLE; // RL22
                end
            end
            default: begin
                nxt_cur.st = drs_pkg::DRS_IDLE;
            end
        endcase
    end

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            cur_ff          <= '0;
            cur_ff.st       <= drs_pkg::DRS_IDLE;
            cur_ff.mfi      <= {`DRS_MFI_NUM{`DRS_MFI_UNUSED}}; // RL5
        end else begin
            cur_ff <= nxt_cur;
        end
    end

    // Decoded drive commands
    always_comb begin
        o_run_fwd    = 1'b0;
        o_run_rev    = 1'b0;
        o_decel      = 1'b0;
        o_base_block = 1'b0;
        o_dc_inject  = 1'b0;
        o_zero_servo = 1'b0;
        o_run_locked = 1'b0;
        case (cur_ff.st)
            drs_pkg::DRS_RUN: begin
                o_run_fwd = !cur_ff.dir_rev;
                o_run_rev = cur_ff.dir_rev;
            end
            drs_pkg::DRS_DECEL: begin
                o_decel = 1'b1;
            end
            drs_pkg::DRS_START_DC: begin
                o_dc_inject  = !i_closed_loop_vector;
                o_zero_servo = i_closed_loop_vector;
            end
            drs_pkg::DRS_STOP_DC: begin
                o_dc_inject  = 1'b1;
                o_run_locked = 1'b1;
            end
            drs_pkg::DRS_ZSERVO: begin
                o_zero_servo = 1'b1;
                o_run_locked = 1'b1;
            end
            drs_pkg::DRS_BBLOCK,
            drs_pkg::DRS_LOCKOUT: begin
                o_base_block = 1'b1;
                o_run_locked = 1'b1;
            end
            default: begin
                // Idle: output off unless the brake terminal asks
                o_dc_inject  = ext_dc && ref_below_zs; // RL21
                o_base_block = !(ext_dc && ref_below_zs);
            end
        endcase
    end

    assign o_dc_current    = cur_ff.dc_cur;
    assign o_three_wire    = three_wire;
    assign o_method_reject = method_reject_w;
    assign o_state         = cur_ff.st;
endmodule

// file: drs_chk.sv
// Assertion checker of the run and stop sequencer
`timescale 1ns/10ps
module drs_chk #(
    parameter int unsigned TICK_CYCLES = 20
) (
    input wire logic        i_clk,
    input wire logic        i_srst,
    input wire logic        i_run_source_select,
    input wire logic [1:0]  i_stop_method_select,
    input wire logic        i_closed_loop_vector,
    input wire logic [15:0] i_zero_speed_level,
    input wire logic [15:0] i_dc_brake_time_start,
    input wire logic [15:0] i_dc_brake_time_stop,
    input wire logic        i_forward_run_input,
    input wire logic        i_reverse_run_input,
    input wire logic [15:0] i_output_freq,
    input wire logic        o_run_fwd,
    input wire logic        o_run_rev,
    input wire logic        o_decel,
    input wire logic        o_base_block,
    input wire logic        o_dc_inject,
    input wire logic [7:0]  o_dc_current,
    input wire logic        o_run_locked,
    input wire logic        o_three_wire,
    input wire logic        o_method_reject,
    input wire logic [2:0]  o_state
);
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_srst);
    wire run = o_run_fwd | o_run_rev;
    wire two = i_run_source_select & ~o_three_wire;
    wire low = i_output_freq < i_zero_speed_level;
    two_start_a: assert property (
        two && o_state == 3'h0 && !o_dc_inject
        && (i_forward_run_input ^ i_reverse_run_input)
        && i_dc_brake_time_start == 16'h0000
        |=> run && o_run_rev == $past(i_reverse_run_input))
        else $error("two-wire start missed");
    two_stop_a: assert property (
        run && two
        && !(o_run_fwd ? i_forward_run_input : i_reverse_run_input)
        |=> !run)
        else $error("two-wire release did not stop");
    ramp_stop_a: assert property (
        $fell(run) && $past(i_stop_method_select) == 2'h0 |-> o_decel)
        else $error("ramp stop not decelerating");
    coast_stop_a: assert property (
        $fell(run) && $past(i_stop_method_select) == 2'h1
        |-> o_base_block && o_run_locked)
        else $error("coast stop kept output");
    timed_stop_a: assert property (
        $fell(run) && $past(i_stop_method_select) == 2'h3
        && !$past(i_closed_loop_vector) |-> o_state == 3'h5 && o_base_block)
        else $error("timed coast not locked out");
    method_rej_a: assert property (
        o_method_reject == (i_closed_loop_vector && i_stop_method_select[1]))
        else $error("method reject flag wrong");
    run_lock_a: assert property (o_run_locked |=> !run)
        else $error("run accepted while locked");
    dc_ramp_a: assert property (
        o_decel && low && !i_closed_loop_vector
        && i_dc_brake_time_stop != 16'h0000 |=> o_dc_inject)
        else $error("ramp end brake missing");
    dc_skip_a: assert property (
        o_decel && low && i_dc_brake_time_stop == 16'h0000 |=> !o_dc_inject)
        else $error("brake with zero stop time");
    clv_cur_a: assert property (
        $past(i_closed_loop_vector) |-> o_dc_current == 8'h00)
        else $error("brake current under vector control");
    cover property ($rose(o_run_rev));
    cover property (o_state == 3'h6);
    cover property (o_state == 3'h5);
    cover property (o_three_wire && run);
endmodule

bind drs_sequencer drs_chk #(.TICK_CYCLES(TICK_CYCLES)) drs_chk_inst (.*);

// file: drs_term_model.sv
// Model of the external switches on the run terminals
`timescale 1ns/10ps
module drs_term_model (
    // Clock
    input  wire logic        i_clk,
    // Commands from the bench
    input  wire logic        i_wire3,
    input  wire logic        i_go,
    input  wire logic        i_rev,
    input  wire logic [15:0] i_hold,
    // Terminals
    output logic             o_s1,
    output logic             o_s2,
    output logic             o_dir
);
    int   cnt  = 0;
    logic go_q = 1'b0;
    // Start button pressed for a set span, then let go
    always @(posedge i_clk) begin
        go_q <= i_go;
        if (i_go && !go_q)
            cnt <= i_hold;
        else if (cnt > 0)
            cnt <= cnt - 1;
    end
    assign o_s1  = i_wire3 ? cnt > 0 : i_go && !i_rev;
    assign o_s2  = i_wire3 ? i_go : i_go && i_rev;
    assign o_dir = i_wire3 && i_rev;
endmodule

// file: tb.sv
// Self-checking bench of the run and stop sequencer
`timescale 1ns/10ps
`include "drs_map.svh"
module tb;
    localparam int T = 20;
    logic i_clk = 0, i_srst = 1, i_run_source_select = 1;
    logic i_closed_loop_vector = 0, i_init_pulse = 0, i_init_three_wire = 0;
    logic i_mfi_wr = 0, i_key_run = 0, i_key_stop = 0, i_key_dir = 0;
    logic [1:0]  i_stop_method_select = 2'h0, i_zero_speed_op_select = 2'h0;
    logic [15:0] i_zero_speed_level = 16'h0032, i_max_freq = 16'h1000;
    logic [15:0] i_dc_brake_time_start = 16'h0000, i_dc_brake_time_stop = 0;
    logic [15:0] i_min_baseblock_time = 16'h0002, i_decel_time_one = 1;
    logic [15:0] i_output_freq = 16'h0800, i_freq_ref = 16'h0800;
    logic [7:0]  i_dc_brake_current = 8'h32, i_mfi_val = 8'h00;
    logic [2:0]  i_mfi_idx = 3'h0;
    logic [4:0]  mhi = 5'h00;
    logic        i_forward_run_input, i_reverse_run_input, s3;
    wire  [5:0]  i_multi_inputs = {mhi, s3};
    logic        w3 = 0, go = 0, rev = 0;
    logic [15:0] hold = 16'h0000;
    logic        o_run_fwd, o_run_rev, o_decel, o_base_block, o_dc_inject;
    logic        o_zero_servo, o_run_locked, o_three_wire, o_method_reject;
    logic [7:0]  o_dc_current;
    logic [2:0]  o_state;
    logic [31:0] seed = 32'h7de736e0;
    int          err_total = 0;
    int          cmp_count = 0;

    always #4 i_clk = ~i_clk;
    drs_sequencer #(.TICK_CYCLES(T)) drs_sequencer_inst (.*);
    drs_term_model drs_term_model_inst (.i_clk(i_clk), .i_wire3(w3),
        .i_go(go), .i_rev(rev), .i_hold(hold), .o_s1(i_forward_run_input),
        .o_s2(i_reverse_run_input), .o_dir(s3));

    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    // Expected ticks: 0 baseblock, 1 brake, 2 lockout
    function automatic int exp_ticks(int m, k, w, bb, st, dt);
        case (w)
            0: return (m == 1 || m == 2) ? bb : 0;
            1: return m == 0 ? st : (m == 2 ? st * (k > 0 ? k : 1) : 0);
            default: return m == 3 ? dt * k : 0;
        endcase
    endfunction
    task automatic chk_val(input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp) begin
            err_total++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic chk_span(input int got, input int lo, input int hi);
        cmp_count++;
        if (got < lo || got > hi) begin
            err_total++;
            $display("CHECK FAILED t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
        end
    endtask
    task automatic give_verdict();
        $display("Comparisons %0d, mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge i_clk);
    endtask
    task automatic wait_idle();
        for (int i = 0; i < 2000 && o_state !== 3'h0; i++) cyc(1);
        cyc(2);
    endtask
    task automatic pulse(input int what);
        i_key_run <= what == 0;
        i_key_stop <= what == 1;
        i_init_pulse <= what == 2;
        i_mfi_wr <= what == 3;
        i_key_dir <= what == 4;
        cyc(1);
        {i_key_run, i_key_stop, i_init_pulse, i_mfi_wr, i_key_dir} <= 5'h00;
        cyc(3);
    endtask
    task automatic stop_run(input int m);
        int f, k, bb, st, dt, e;
        int n[3];
        logic r;
        r = rnd() % 2;
        f = 'h200 + rnd() % 'he00;
        k = f * 10 / 'h1000;
        bb = 1 + rnd() % 3;
        st = (m == 2) + rnd() % 3;
        dt = 1 + rnd() % 3;
        n = '{0, 0, 0};
        i_stop_method_select <= 2'(m);
        i_output_freq <= 16'(f);
        i_min_baseblock_time <= 16'(bb);
        i_dc_brake_time_stop <= 16'(st);
        i_decel_time_one <= 16'(dt);
        i_dc_brake_current <= 8'(rnd());
        rev <= r;
        go <= 1'b1;
        cyc(4);
        chk_val(16'({o_run_fwd, o_run_rev}), 16'({!r, r}));
        chk_val(16'(o_dc_current), 16'(i_dc_brake_current));
        go <= 1'b0;
        for (e = 0; e < 2000; e++) begin
            cyc(1);
            if (o_decel) i_output_freq <= 16'h0000;
            n[0] += o_state == 3'h7;
            n[1] += o_dc_inject;
            n[2] += o_state == 3'h5;
            if (o_state == 3'h0) break;
        end
        for (int w = 0; w < 3; w++) begin
            e = exp_ticks(m, k, w, bb, st, dt);
            chk_span(n[w], e > 0 ? (e - 1) * T : 0, e * T + 3);
        end
        $display("Test stop method %0d done", m);
    endtask

    initial begin
        int n;
        n = 0;
        cyc(20);
        i_srst <= 1'b0;
        cyc(2);
        chk_val(16'({o_state, o_base_block, o_three_wire}), 16'h0002);
        for (int m = 0; m < 10; m++) stop_run(m < 4 ? m : rnd() % 4);
        i_dc_brake_time_start <= 16'h0002;
        go <= 1'b1;
        for (int i = 0; i < 200 && o_state !== 3'h3; i++) begin
            cyc(1);
            n += o_dc_inject;
        end
        chk_span(n, T, 2 * T + 3);
        i_dc_brake_time_start <= 16'h0000;
        go <= 1'b0;
        wait_idle();
        i_closed_loop_vector <= 1'b1;
        i_stop_method_select <= 2'h2;
        i_output_freq <= 16'h0800;
        go <= 1'b1;
        cyc(4);
        chk_val(16'({o_method_reject, o_dc_current}), 16'h0100);
        go <= 1'b0;
        cyc(3);
        chk_val(16'(o_decel), 16'h0001);
        i_output_freq <= 16'h0000;
        i_zero_speed_op_select <= 2'h1;
        cyc(2);
        chk_val(16'(o_zero_servo), 16'h0001);
        wait_idle();
        i_closed_loop_vector <= 1'b0;
        $display("Test start brake and vector done");
        i_run_source_select <= 1'b0;
        go <= 1'b1;
        cyc(4);
        chk_val(16'(o_run_fwd), 16'h0000);
        go <= 1'b0;
        pulse(4);
        pulse(0);
        chk_val(16'(o_run_rev), 16'h0001);
        pulse(1);
        chk_val(16'(o_run_rev), 16'h0000);
        wait_idle();
        i_run_source_select <= 1'b1;
        pulse(0);
        chk_val(16'(o_run_fwd), 16'h0000);
        $display("Test panel done");
        i_init_three_wire <= 1'b1;
        pulse(2);
        w3 <= 1'b1;
        chk_val(16'(o_three_wire), 16'h0001);
        hold <= 16'(2 * T);
        rev <= 1'b1;
        go <= 1'b1;
        cyc(8 * T);
        chk_val(16'({o_run_fwd, o_run_rev}), 16'h0000);
        go <= 1'b0;
        cyc(2);
        hold <= 16'(6 * T);
        go <= 1'b1;
        cyc(10 * T);
        chk_val(16'({o_run_fwd, o_run_rev}), 16'h0001);
        go <= 1'b0;
        wait_idle();
        w3 <= 1'b0;
        i_init_three_wire <= 1'b0;
        pulse(2);
        chk_val(16'(o_three_wire), 16'h0000);
        i_mfi_idx <= 3'h3;
        i_mfi_val <= `DRS_MFI_THREE_WIRE;
        pulse(3);
        chk_val(16'(o_three_wire), 16'h0001);
        pulse(2);
        i_mfi_idx <= 3'h2;
        i_mfi_val <= `DRS_MFI_DC_BRAKE;
        pulse(3);
        mhi <= 5'h02;
        i_freq_ref <= 16'h0000;
        cyc(3);
        chk_val(16'(o_dc_inject), 16'h0001);
        i_freq_ref <= 16'h0400;
        cyc(3);
        chk_val(16'(o_dc_inject), 16'h0000);
        mhi <= 5'h00;
        $display("Test terminal modes done");
        give_verdict();
    end

    initial begin
        cyc(60000);
        err_total++;
        $display("Watchdog expired");
        give_verdict();
    end
endmodule
